// >>> dv/radio_modem_host_control_tb.sv
// Self-checking bench for the host controller and modem pair.
`timescale 1ns/1ps
`default_nettype none
module radio_modem_host_control_tb
  import rmc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  logic crc_good = 1'b0;
  logic [7:0] trim;
  logic signed [8:0] step;
  logic idle;
  logic [31:0] rd_q;
  logic err_q;
  int n_errors = 0;
  int total_checks = 0;

  rmc_link_if lnk ();
  rmc_host #(.HALF_CYCLES(8)) rmc_host_inst (.CLK_I(clk), .RST_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .lnk(lnk));
  rmc_modem #(.STARTUP_CYCLES(50), .ACT_CYCLES(64)) rmc_modem_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .CRC_GOOD_I(crc_good),
    .XTAL_TRIM_O(trim), .REF_STEP_O(step), .MODEM_IDLE_O(idle), .lnk(lnk));
  rmc_props #(.STARTUP_CYCLES(50)) rmc_props_inst (.CLK_I(clk),
    .RST_N_I(rst_n), .reset_n(lnk.reset_n), .wake_n(lnk.wake_n),
    .sck(lnk.sck), .ce_n(lnk.ce_n), .miso(lnk.miso),
    .irq_out(lnk.irq_out), .irq_oe_n(lnk.irq_oe_n),
    .irq_pu_en(lnk.irq_pu_en), .irq_drive(lnk.irq_drive),
    .clock_output_pin(lnk.clock_output_pin), .g1_oe_n(lnk.g1_oe_n), .g2_oe_n(lnk.g2_oe_n),
    .irq_n(lnk.irq_n));

  // A 40 ns period gives the 25 MHz system clock.
  always #20 clk = ~clk;

  // Prints the tallies and the verdict, then stops the run.
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; the request stands until ready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Ready and data are taken at the rising edge that ends the access.
    @(posedge clk);
    while (prdy !== 1'b1) begin
      @(posedge clk);
    end
    rd_q = prd;
    err_q = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Polls the status word until one bit takes the wanted value.
  task automatic waitbit(input int i, input logic v);
    apb(1'b0, HA_STATUS, 32'h0);
    while (rd_q[i] !== v) begin
      apb(1'b0, HA_STATUS, 32'h0);
    end
  endtask

  // Reads a host register and compares the masked bits.
  task automatic hrd(input string nm, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_q & m);
  endtask

  // A write that must be refused with an error response.
  task automatic errw(input string nm, input logic [7:0] a);
    apb(1'b1, a, 32'h1);
    chk(nm, 32'h1, {31'h0, err_q});
  endtask

  // Sends one serial frame and waits until the link is free again.
  task automatic cmd(input logic r, input logic [5:0] a,
    input logic [15:0] d);
    apb(1'b1, HA_CMD, {8'h00, r, 1'b0, a, d});
    waitbit(0, 1'b0);
  endtask

  // Reads a modem register over the link and compares it.
  task automatic mrd(input string nm, input logic [5:0] a,
    input logic [15:0] e);
    cmd(1'b1, a, 16'h0000);
    chk(nm, {16'h0, e}, {16'h0, rd_q[31:16]});
  endtask

  // Main sequence; each step leans on the state left by the one before.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    hrd("ctrl", HA_CTRL, 32'h7, 32'h1);
    hrd("held", HA_STATUS, 32'h6, 32'h0);
    errw("unmapped", 8'h0c);
    errw("status_wr", HA_STATUS);
    errw("early_cmd", HA_CMD);
    apb(1'b1, HA_CTRL, 32'h0);
    waitbit(2, 1'b1);
    chk("idle", 32'h1, {31'h0, idle});
    hrd("irq_up", HA_STATUS, 32'h2, 32'h2);
    mrd("mask", MA_IRQ_MASK, 16'h0001);
    mrd("clkctl", MA_CLOCK_OUTPUT_CONTROL, CLOCK_OUTPUT_CONTROL_RST);
    mrd("evt", MA_IRQ_STATUS, 16'h0001);
    hrd("released", HA_STATUS, 32'h2, 32'h0);
    cmd(1'b0, MA_CLOCK_OUTPUT_CONTROL, 16'h3c0e);
    chk("trim", 32'h3c, {24'h0, trim});
    chk("step", 32'h1c4, {23'h0, step});
    mrd("trim_rd", MA_CLOCK_OUTPUT_CONTROL, 16'h3c0e);
    apb(1'b1, HA_CTRL, 32'h2);
    waitbit(1, 1'b1);
    mrd("wake_evt", MA_IRQ_STATUS, 16'h0001);
    hrd("wake_rel", HA_STATUS, 32'h2, 32'h0);
    cmd(1'b0, MA_PIN_CFG, 16'h0019);
    cmd(1'b0, MA_RADIO_CTL, {14'h0, MODE_RX});
    crc_good <= 1'b1;
    apb(1'b1, HA_CTRL, 32'h4);
    waitbit(3, 1'b1);
    hrd("crc_clr", HA_STATUS, 32'h10, 32'h0);
    waitbit(3, 1'b0);
    hrd("crc_ok", HA_STATUS, 32'h10, 32'h10);
    apb(1'b1, HA_CTRL, 32'h0);
    hrd("no_irq", HA_STATUS, 32'h2, 32'h0);
    cmd(1'b0, MA_IRQ_MASK, 16'h0003);
    waitbit(1, 1'b1);
    mrd("done_evt", MA_IRQ_STATUS, 16'h0002);
    hrd("done_rel", HA_STATUS, 32'h2, 32'h0);
    cmd(1'b0, MA_PIN_CFG, 16'h01a1);
    hrd("gpio", HA_STATUS, 32'h18, 32'h08);
    mrd("pin_in", MA_PIN_IN, 16'h0001);
    apb(1'b1, HA_CTRL, 32'h1);
    hrd("rst_rel", HA_STATUS, 32'h6, 32'h0);
    apb(1'b1, HA_CTRL, 32'h0);
    waitbit(1, 1'b1);
    end_sim();
  end

  // Cuts a hang short; the sequence needs well under this span.
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire

// >>> dv/rmc_props.sv
// Concurrent checks on the pins between host controller and modem.
`timescale 1ns/1ps
`default_nettype none
module rmc_props #(
  parameter int STARTUP_CYCLES = 50
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic reset_n,
  input wire logic wake_n,
  input wire logic sck,
  input wire logic ce_n,
  input wire logic miso,
  input wire logic irq_out,
  input wire logic irq_oe_n,
  input wire logic irq_pu_en,
  input wire logic [1:0] irq_drive,
  input wire logic clock_output_pin,
  input wire logic g1_oe_n,
  input wire logic g2_oe_n,
  input wire logic irq_n
);
  logic [9:0] up_r;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Cycles since the modem left reset; saturates so it never wraps.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      up_r <= 10'h000;
    end else if (!reset_n) begin
      up_r <= 10'h000;
    end else if (up_r != 10'h3ff) begin
      up_r <= up_r + 10'h001;
    end
  end

  a_reset_quiet: assert property (!reset_n |->
    irq_oe_n && !clock_output_pin && !miso && g1_oe_n && g2_oe_n)
    else $error("modem drives pins while in reset");
  a_no_early_irq: assert property (
    reset_n && up_r < STARTUP_CYCLES |-> irq_n)
    else $error("request before start-up ends");
  a_start_irq: assert property ($rose(reset_n) |->
    ##[40:60] !irq_n) else $error("no request after start-up");
  a_clock_output_pin_hold: assert property ($changed(clock_output_pin) |=>
    $stable(clock_output_pin) [*8]) else $error("clock output too fast");
  a_open_drain: assert property (!irq_oe_n |-> !irq_out)
    else $error("request line driven high");
  a_wake_irq: assert property ($fell(wake_n) &&
    up_r > STARTUP_CYCLES + 8 |-> ##[1:6] !irq_n)
    else $error("wake did not raise request");
  a_sck_idle: assert property (ce_n |-> !sck)
    else $error("shift clock runs outside frame");
  a_sck_half: assert property ($rose(sck) |->
    sck [*8] ##1 !sck) else $error("shift clock half period");
  a_miso_idle: assert property (ce_n [*4] |-> !miso)
    else $error("data out not idle");
  a_pullup_rst: assert property (
    up_r > 10'h000 && up_r < 10'h028 |-> irq_pu_en && irq_drive == 2'h0)
    else $error("pull-up not on after reset");
  a_frame_hold: assert property ($fell(ce_n) |-> !ce_n [*8])
    else $error("frame cut short");

  c_frame: cover property ($fell(ce_n));
  c_release: cover property (reset_n && $rose(irq_n));
  c_clock_output_pin: cover property ($rose(clock_output_pin));
endmodule
`default_nettype wire

// >>> pkg/rmc_link_if.sv
// Pin-level link between the host controller and the modem.
`timescale 1ns/1ps
`default_nettype none
interface rmc_link_if;
  logic reset_n;
  logic wake_n;
  logic radio_en;
  logic sck;
  logic mosi;
  logic ce_n;
  logic miso;
  logic irq_out;
  logic irq_oe_n;
  logic irq_pu_en;
  logic [1:0] irq_drive;
  logic clock_output_pin;
  logic g1_out;
  logic g1_oe_n;
  logic g2_out;
  logic g2_oe_n;
  logic irq_n;
  logic g1;
  logic g2;

  // Open-drain request line: pulled high unless the modem sinks it.
  assign irq_n = irq_oe_n | irq_out;
  // Status pins have no pull-up; an undriven pin reads low here.
  assign g1 = ~g1_oe_n & g1_out;
  assign g2 = ~g2_oe_n & g2_out;

  modport modem(input reset_n, input wake_n, input radio_en, input sck,
    input mosi, input ce_n, input g1, input g2, output miso,
    output irq_out, output irq_oe_n, output irq_pu_en, output irq_drive,
    output clock_output_pin, output g1_out, output g1_oe_n, output g2_out,
    output g2_oe_n);

  modport host(output reset_n, output wake_n, output radio_en,
    output sck, output mosi, output ce_n, input miso, input irq_n,
    input clock_output_pin, input g1, input g2);
endinterface
`default_nettype wire

// >>> pkg/rmc_pkg.sv
// Shared constants and types for the radio modem host control link.
package rmc_pkg;

  // System clock and startup timing.
  localparam int CLK_HZ = 25_000_000;
  localparam int STARTUP_MS = 10;
  localparam int STARTUP_CYC = CLK_HZ / 1000 * STARTUP_MS;

  // Serial link timing; the half period must not fall below the minimum.
  localparam int SCK_MAX_HZ = 8_000_000;
  localparam int SCK_HALF_MIN = (CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
  localparam int SCK_HALF_CYC = 8;
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS = 8;
  localparam int ACT_CYC = 64;

  // Frame layout: read flag, address, data.
  localparam int FR_RD_BIT = 23;
  localparam int HDR_RD_BIT = 7;

  // Modem register addresses.
  localparam logic [5:0] MA_IRQ_MASK = 6'h05;
  localparam logic [5:0] MA_RADIO_CTL = 6'h06;
  localparam logic [5:0] MA_CLOCK_OUTPUT_CONTROL = 6'h0a;
  localparam logic [5:0] MA_PIN_CFG = 6'h0b;
  localparam logic [5:0] MA_PIN_IN = 6'h0c;
  localparam logic [5:0] MA_IRQ_STATUS = 6'h24;

  // Modem register reset values.
  localparam logic [15:0] IRQ_MASK_RST = 16'h0001;
  localparam logic [15:0] IRQ_STAT_RST = 16'h0001;
  localparam logic [15:0] RADIO_CTL_RST = 16'h0000;
  localparam logic [15:0] CLOCK_OUTPUT_CONTROL_RST = 16'h800e;
  localparam logic [15:0] PIN_CFG_RST = 16'h0001;

  // Modem field positions.
  localparam int ST_WAKE_REQUEST_N = 0;
  localparam int ST_DONE = 1;
  localparam int TRIM_LSB = 8;
  localparam int CLOCK_OUTPUT_PIN_EN_BIT = 3;
  localparam int PC_PU = 0;
  localparam int PC_DRV_LSB = 1;
  localparam int PC_G1_ALT = 3;
  localparam int PC_G2_ALT = 4;
  localparam int PC_G1_OE = 5;
  localparam int PC_G2_OE = 6;
  localparam int PC_G1_VAL = 7;
  localparam int PC_G2_VAL = 8;
  localparam logic [1:0] MODE_RX = 2'h1;

  // Host register offsets, reset value and fields.
  localparam logic [7:0] HA_CTRL = 8'h00;
  localparam logic [7:0] HA_CMD = 8'h04;
  localparam logic [7:0] HA_STATUS = 8'h08;
  localparam logic [2:0] CTRL_RST = 3'h1;
  localparam int CT_RESET = 0;
  localparam int CT_WAKE = 1;
  localparam int CT_RADIO = 2;

  // Clock output rates selected by the three low control bits.
  localparam int CLOCK_OUTPUT_PIN_HZ [8] = '{16_000_000, 8_000_000, 4_000_000,
    2_000_000, 1_000_000, 62_500, 32_768, 16_384};

  typedef enum logic [1:0] {PWR_UP, PWR_IDLE, PWR_ACTIVE} rmc_pwr_type;

  // Half period in system cycles; fast rates clamp to one cycle.
  function automatic logic [15:0] clock_output_pin_half(input logic [2:0] sel);
    int h;
    h = CLK_HZ / (2 * CLOCK_OUTPUT_PIN_HZ[sel]);
    if (h < 1) begin
      h = 1;
    end
    return 16'(h);
  endfunction

endpackage

// >>> verilog/rmc_host.sv
// Host end: APB register block driving the modem pins and serial master.
`timescale 1ns/1ps
`default_nettype none
module rmc_host
  import rmc_pkg::*;
#(
  parameter int HALF_CYCLES = SCK_HALF_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  rmc_link_if.host lnk
);

  // Synchronised pin order: clock_output_pin, g2, g1, irq_n, miso.
  logic [4:0] in_m_r;
  logic [4:0] in_s_r;
  logic [2:0] ctrl_r;
  logic alive_r;
  logic busy_r;
  logic acc;
  logic stall;
  logic bad;
  logic do_wr;
  logic start;
  logic [31:0] rd_mux;
  logic [7:0] div_r;
  logic [4:0] bits_r;
  logic [22:0] sh_r;
  logic [15:0] rx_r;
  logic [15:0] rd_data_r;
  logic sck_r;
  logic mosi_r;
  logic ce_n_r;

  // Pin inputs pass two flops before any logic reads them.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      in_m_r <= 5'h02;
      in_s_r <= 5'h02;
    end else begin
      in_m_r <= {lnk.clock_output_pin, lnk.g2, lnk.g1, lnk.irq_n, lnk.miso};
      in_s_r <= in_m_r;
    end
  end

  // A command write waits while a frame is in flight; pready stays low.
  assign acc = PSEL_I & PENABLE_I & ~PREADY_O;
  assign stall = PWRITE_I & (PADDR_I == HA_CMD) & busy_r;
  assign bad = (PADDR_I != HA_CTRL && PADDR_I != HA_CMD &&
                PADDR_I != HA_STATUS) ||
               (PWRITE_I && PADDR_I == HA_CMD && !alive_r) ||
               (PWRITE_I && PADDR_I == HA_STATUS);
  assign do_wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & ~PSLVERR_O;
  assign start = do_wr & (PADDR_I == HA_CMD);

  // Status word: last read data over the pin and engine flags.
  always_comb begin
    rd_mux = 32'h00000000;
    case (PADDR_I)
      HA_CTRL: rd_mux = {29'h00000000, ctrl_r};
      HA_STATUS: rd_mux = {rd_data_r, 10'h000, in_s_r[4:2], alive_r,
                           ~in_s_r[1], busy_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Answer one cycle into the access phase; writes land on the next edge, which ends the access.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
    end else begin
      PREADY_O <= acc & ~stall;
      PSLVERR_O <= acc & ~stall & bad;
      PRDATA_O <= (acc && !stall && !PWRITE_I && !bad) ? rd_mux
                                                       : 32'h00000000;
    end
  end

  // reset pin driven low
  // The modem stays in reset from host reset until software releases it.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_r <= CTRL_RST;
    end else if (do_wr && PADDR_I == HA_CTRL) begin
      ctrl_r <= PWDATA_I[2:0];
    end
  end

  // wait for request
  // The request seen wins over a reset held in the same cycle.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      alive_r <= 1'b0;
    end else if (!in_s_r[1]) begin
      alive_r <= 1'b1;
    end else if (ctrl_r[CT_RESET]) begin
      alive_r <= 1'b0;
    end
  end

  // serial clock limit
  // Half periods of HALF_CYCLES keep the clock well under the limit and
  // leave the modem's sampled read data time to cross back.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_r <= 1'b0;
      div_r <= 8'h00;
      bits_r <= 5'h00;
      sh_r <= 23'h000000;
      rx_r <= 16'h0000;
      rd_data_r <= 16'h0000;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      ce_n_r <= 1'b1;
    end else if (start) begin
      busy_r <= 1'b1;
      div_r <= 8'h00;
      bits_r <= 5'h00;
      sh_r <= PWDATA_I[22:0];
      mosi_r <= PWDATA_I[FR_RD_BIT];
      sck_r <= 1'b0;
      ce_n_r <= 1'b0;
    end else if (busy_r) begin
      if (div_r != 8'(HALF_CYCLES - 1)) begin
        div_r <= div_r + 8'h01;
      end else begin
        div_r <= 8'h00;
        if (ce_n_r) begin
          busy_r <= 1'b0;
        end else if (!sck_r) begin
          sck_r <= 1'b1;
          rx_r <= {rx_r[14:0], in_s_r[0]};
          bits_r <= bits_r + 5'h01;
        end else begin
          sck_r <= 1'b0;
          if (bits_r == 5'(FRAME_BITS)) begin
            ce_n_r <= 1'b1;
            mosi_r <= 1'b0;
            rd_data_r <= rx_r;
          end else begin
            mosi_r <= sh_r[22];
            sh_r <= {sh_r[21:0], 1'b0};
          end
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lnk.reset_n <= 1'b0;
      lnk.wake_n <= 1'b1;
      lnk.radio_en <= 1'b0;
    end else begin
      lnk.reset_n <= ~ctrl_r[CT_RESET];
      lnk.wake_n <= ~ctrl_r[CT_WAKE];
      lnk.radio_en <= ctrl_r[CT_RADIO];
    end
  end

  assign lnk.sck = sck_r;
  assign lnk.mosi = mosi_r;
  assign lnk.ce_n = ce_n_r;

endmodule
`default_nettype wire

// >>> verilog/rmc_modem.sv
// Modem end: reset, power-up, serial registers, request line, status pins.
// Behaviour
// - Hard reset is asynchronous, active low.
// - In reset, everything off, no clocks.
// - Reach idle 10 to 25 ms after release.
// - At idle raise request, start clock output.
// - Attention flag and mask set out of reset.
// - Wake input assertion raises attention request.
// - Host waits for request before programming.
// - Host drives reset pin low at init.
// - Modem is serial slave, host is master.
// - Host keeps serial clock at most 8 MHz.
// - Serial commands read and write registers.
// - Request line pulled low while pending.
// - Reading event status releases request line.
// - Request pull-up default on, drive programmable.
// - Radio enable input permits radio operations.
// - Pin one: radio active or general I/O.
// - Pin two: check passed or general I/O.
// - Eight-bit trim in clock control bits 15:8.
// - Higher trim code lowers reference frequency.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rmc_modem
  import rmc_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC,
  parameter int ACT_CYCLES = ACT_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CRC_GOOD_I,
  output logic [7:0] XTAL_TRIM_O,
  output logic signed [8:0] REF_STEP_O,
  output logic MODEM_IDLE_O,
  rmc_link_if.modem lnk
);

  // Synchronised pin order: g2, g1, radio_en, wake_n, ce_n, mosi, sck.
  localparam logic [6:0] SYNC_RST = 7'h0c;

  logic rst_a_n;
  logic rst_m_r;
  logic rst_n_r;
  logic [6:0] in_m_r;
  logic [6:0] in_s_r;
  logic [6:0] in_d_r;
  logic sck_rise;
  logic sck_fall;
  logic ce_act;
  logic [4:0] bit_cnt_r;
  logic [22:0] rx_r;
  logic [15:0] tx_r;
  logic rd_r;
  logic [5:0] addr_r;
  logic [7:0] hdr;
  logic hdr_done;
  logic frame_done;
  logic [15:0] wr_data;
  logic [15:0] rd_mux;
  logic [15:0] snap_r;
  logic [15:0] irq_mask_r;
  logic [15:0] irq_stat_r;
  logic [15:0] radio_ctl_r;
  logic [15:0] clock_output_control_r;
  logic [15:0] pin_cfg_r;
  logic [15:0] stat_set;
  logic [15:0] stat_clr;
  rmc_pwr_type pwr_r;
  logic [31:0] cyc_r;
  logic act_end;
  logic radio_rise;
  logic crc_valid_r;
  logic [15:0] div_r;
  logic irq_pend;
  logic miso_r;
  logic irq_out_r;
  logic irq_oe_n_r;
  logic clock_output_pin_r;
  logic g1_out_r;
  logic g1_oe_n_r;
  logic g2_out_r;
  logic g2_oe_n_r;

  // async hard reset
  // Either reset source clears the modem at once; release is synchronised
  // so no flop leaves reset on a different edge than its neighbours.
  assign rst_a_n = RST_N_I & lnk.reset_n;
  always_ff @(posedge CLK_I or negedge rst_a_n) begin
    if (!rst_a_n) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // Every pin input passes two flops; a third copy gives edge detection.
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      in_m_r <= SYNC_RST;
      in_s_r <= SYNC_RST;
      in_d_r <= SYNC_RST;
    end else begin
      in_m_r <= {lnk.g2, lnk.g1, lnk.radio_en, lnk.wake_n, lnk.ce_n,
                 lnk.mosi, lnk.sck};
      in_s_r <= in_m_r;
      in_d_r <= in_s_r;
    end
  end

  // slave edge detection
  // The modem never drives the serial clock; it only watches it.
  assign sck_rise = in_s_r[0] & ~in_d_r[0];
  assign sck_fall = ~in_s_r[0] & in_d_r[0];
  assign ce_act = ~in_s_r[2] & (pwr_r != PWR_UP);
  assign hdr = {rx_r[6:0], in_s_r[1]};
  assign hdr_done = ce_act & sck_rise & (bit_cnt_r == 5'(HDR_BITS - 1));
  assign frame_done = ce_act & sck_rise & (bit_cnt_r == 5'(FRAME_BITS - 1));
  assign wr_data = {rx_r[14:0], in_s_r[1]};

  always_comb begin
    rd_mux = 16'h0000;
    case (hdr[5:0])
      MA_IRQ_MASK: rd_mux = irq_mask_r;
      MA_RADIO_CTL: rd_mux = radio_ctl_r;
      MA_CLOCK_OUTPUT_CONTROL: rd_mux = clock_output_control_r;
      MA_PIN_CFG: rd_mux = pin_cfg_r;
      MA_PIN_IN: rd_mux = {14'h0000, in_s_r[6:5]};
      MA_IRQ_STATUS: rd_mux = irq_stat_r;
      default: rd_mux = 16'h0000;
    endcase
  end

  // Shift engine: bits in on rising edges, read data out on falling ones.
  // A frame cut short by chip enable leaves every register untouched.
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bit_cnt_r <= 5'h00;
      rx_r <= 23'h000000;
      tx_r <= 16'h0000;
      rd_r <= 1'b0;
      addr_r <= 6'h00;
      snap_r <= 16'h0000;
      miso_r <= 1'b0;
    end else if (!ce_act) begin
      bit_cnt_r <= 5'h00;
      miso_r <= 1'b0;
    end else begin
      if (sck_rise) begin
        rx_r <= {rx_r[21:0], in_s_r[1]};
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
      if (hdr_done) begin
        rd_r <= hdr[HDR_RD_BIT];
        addr_r <= hdr[5:0];
        tx_r <= rd_mux;
        snap_r <= (hdr[5:0] == MA_IRQ_STATUS) ? irq_stat_r : 16'h0000;
      end else if (sck_fall && bit_cnt_r >= 5'(HDR_BITS)) begin
        miso_r <= tx_r[15];
        tx_r <= {tx_r[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_mask_r <= IRQ_MASK_RST;
      radio_ctl_r <= RADIO_CTL_RST;
      clock_output_control_r <= CLOCK_OUTPUT_CONTROL_RST;
      pin_cfg_r <= PIN_CFG_RST;
    end else if (frame_done && !rd_r) begin
      case (addr_r)
        MA_IRQ_MASK: irq_mask_r <= wr_data;
        MA_RADIO_CTL: radio_ctl_r <= wr_data;
        MA_CLOCK_OUTPUT_CONTROL: clock_output_control_r <= wr_data;
        MA_PIN_CFG: pin_cfg_r <= wr_data;
        default: irq_mask_r <= irq_mask_r;
      endcase
    end
  end

  // radio enable gating
  // Dropping the radio enable aborts an operation without a done event.
  // Only a rise of the enable starts one; a held level would restart at
  // once and wipe the result flags before the host could see them.
  assign radio_rise = in_s_r[4] & ~in_d_r[4];
  assign act_end = (pwr_r == PWR_ACTIVE) & (cyc_r == 32'(ACT_CYCLES - 1));
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pwr_r <= PWR_UP;
      cyc_r <= 32'h00000000;
    end else begin
      unique case (pwr_r)
        PWR_UP: begin
          cyc_r <= cyc_r + 32'h00000001;
          if (cyc_r == 32'(STARTUP_CYCLES - 1)) begin
            pwr_r <= PWR_IDLE;
            cyc_r <= 32'h00000000;
          end
        end
        PWR_IDLE: begin
          cyc_r <= 32'h00000000;
          if (radio_rise && radio_ctl_r[1:0] != 2'h0) begin
            pwr_r <= PWR_ACTIVE;
          end
        end
        PWR_ACTIVE: begin
          cyc_r <= cyc_r + 32'h00000001;
          if (!in_s_r[4] || act_end) begin
            pwr_r <= PWR_IDLE;
          end
        end
      endcase
    end
  end

  // status read clears
  // A new event in the clearing cycle survives because set wins.
  assign stat_set = {14'h0000, act_end, in_d_r[3] & ~in_s_r[3]};
  assign stat_clr = (frame_done && rd_r && addr_r == MA_IRQ_STATUS)
                    ? snap_r : 16'h0000;
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_stat_r <= IRQ_STAT_RST;
    end else begin
      irq_stat_r <= (irq_stat_r & ~stat_clr) | stat_set;
    end
  end

  // pending while unmasked remain
  // Nothing is signalled during power-up, even though the flag is preset.
  assign irq_pend = (|(irq_stat_r & irq_mask_r)) & (pwr_r != PWR_UP);
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_out_r <= 1'b1;
      irq_oe_n_r <= 1'b1;
    end else begin
      irq_out_r <= ~irq_pend;
      irq_oe_n_r <= ~irq_pend;
    end
  end

  // clock output divider
  // The divider only approximates rates whose half period is not a whole number of cycles.
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_r <= 16'h0000;
      clock_output_pin_r <= 1'b0;
    end else if (pwr_r == PWR_UP || !clock_output_control_r[CLOCK_OUTPUT_PIN_EN_BIT]) begin
      div_r <= 16'h0000;
      clock_output_pin_r <= 1'b0;
    end else if (div_r >= clock_output_pin_half(clock_output_control_r[2:0]) - 16'h0001) begin
      div_r <= 16'h0000;
      clock_output_pin_r <= ~clock_output_pin_r;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // check-passed indicator
  // Holds from the end of a good receive until the next operation starts.
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      crc_valid_r <= 1'b0;
    end else if (pwr_r == PWR_IDLE && radio_rise &&
                 radio_ctl_r[1:0] != 2'h0) begin
      crc_valid_r <= 1'b0;
    end else if (act_end && radio_ctl_r[1:0] == MODE_RX) begin
      crc_valid_r <= CRC_GOOD_I;
    end
  end

  // pin one and pin two function
  // Alternate functions always drive; general pins drive only on request.
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      g1_out_r <= 1'b0;
      g1_oe_n_r <= 1'b1;
      g2_out_r <= 1'b0;
      g2_oe_n_r <= 1'b1;
    end else begin
      g1_out_r <= pin_cfg_r[PC_G1_ALT] ? (pwr_r == PWR_ACTIVE)
                                       : pin_cfg_r[PC_G1_VAL];
      g1_oe_n_r <= ~(pin_cfg_r[PC_G1_ALT] | pin_cfg_r[PC_G1_OE]);
      g2_out_r <= pin_cfg_r[PC_G2_ALT] ? crc_valid_r : pin_cfg_r[PC_G2_VAL];
      g2_oe_n_r <= ~(pin_cfg_r[PC_G2_ALT] | pin_cfg_r[PC_G2_OE]);
    end
  end

  // pull-up and drive
  // The step sign is negative: a larger code slows the reference.
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      XTAL_TRIM_O <= 8'h00;
      REF_STEP_O <= 9'sh000;
      MODEM_IDLE_O <= 1'b0;
      lnk.irq_pu_en <= PIN_CFG_RST[PC_PU];
      lnk.irq_drive <= PIN_CFG_RST[PC_DRV_LSB +: 2];
    end else begin
      XTAL_TRIM_O <= clock_output_control_r[TRIM_LSB +: 8];
      REF_STEP_O <= -$signed({1'b0, clock_output_control_r[TRIM_LSB +: 8]});
      MODEM_IDLE_O <= (pwr_r == PWR_IDLE);
      lnk.irq_pu_en <= pin_cfg_r[PC_PU];
      lnk.irq_drive <= pin_cfg_r[PC_DRV_LSB +: 2];
    end
  end

  // Link outputs straight from their flops.
  assign lnk.miso = miso_r;
  assign lnk.irq_out = irq_out_r;
  assign lnk.irq_oe_n = irq_oe_n_r;
  assign lnk.clock_output_pin = clock_output_pin_r;
  assign lnk.g1_out = g1_out_r;
  assign lnk.g1_oe_n = g1_oe_n_r;
  assign lnk.g2_out = g2_out_r;
  assign lnk.g2_oe_n = g2_oe_n_r;

endmodule
`default_nettype wire
